// ---- logic/iwd_pkg.sv ----
// Package for the I/O-port watchdog: port addresses, register indices, codes.
// Assumes a single 250 MHz clock domain.
package iwd_pkg;
    localparam logic [15:0] IDX_PORT     = 16'h002E;
    localparam logic [15:0] DATA_PORT    = 16'h002F;
    localparam logic [7:0]  UNLOCK_CODE  = 8'h87;
    localparam logic [7:0]  LOCK_CODE    = 8'hAA;
    localparam logic [7:0]  REG_LDN      = 8'h07;
    localparam logic [7:0]  REG_ENABLE   = 8'h30;
    localparam logic [7:0]  REG_ACTIVATE = 8'hF0;
    localparam logic [7:0]  REG_TBASE    = 8'hF5;
    localparam logic [7:0]  REG_TVALUE   = 8'hF6;
    localparam logic [7:0]  WATCHDOG_LDN = 8'h07;
    localparam logic [7:0]  ENABLE_VAL   = 8'h01;
    localparam logic [7:0]  ACTIVATE_VAL = 8'h80;
    localparam logic [7:0]  TB_SECONDS   = 8'h71;
    localparam logic [7:0]  TB_MINUTES   = 8'h79;
    localparam logic [7:0]  RST_ZERO     = 8'h00;
    localparam int unsigned CLK_HZ       = 250_000_000;
    localparam int unsigned SEC_PER_MIN  = 60;
    localparam int unsigned TICK_SEC     = 1;
    localparam int unsigned SEC_CYCLES   = CLK_HZ * TICK_SEC;
    localparam int unsigned RESET_PULSE  = 16;
endpackage : iwd_pkg

// ---- logic/iwd_tick.sv ----
// Time-base tick generator: one-cycle pulse per second or per minute.
// Assumes restart is pulsed whenever the countdown is reloaded.
`timescale 1ns/100ps
`default_nettype none
module iwd_tick #(
    parameter int unsigned SEC_CYCLES = iwd_pkg::SEC_CYCLES
) (
    input  wire logic clock,
    input  wire logic rst,
    input  wire logic run,
    input  wire logic restart,
    input  wire logic minutes,
    output logic      tick
);
    import iwd_pkg::*;

    typedef struct packed {
        logic [31:0] cyc;
        logic [5:0]  sec;
        logic        tick;
    } iwd_tick_st_t;

    iwd_tick_st_t st_ff;
    iwd_tick_st_t nxt_st;

    always_comb begin
        nxt_st = st_ff;
        nxt_st.tick = 1'b0;
        if (!run || restart) begin
            nxt_st.cyc = 32'h0;
            nxt_st.sec = 6'h0;
        end else if (st_ff.cyc == SEC_CYCLES - 1) begin
            nxt_st.cyc = 32'h0;
            if (!minutes || st_ff.sec == 6'(SEC_PER_MIN - 1)) begin
                nxt_st.sec = 6'h0;
                nxt_st.tick = 1'b1;
            end else begin
                nxt_st.sec = st_ff.sec + 6'h1;
            end
        end else begin
            nxt_st.cyc = st_ff.cyc + 32'h1;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign tick = st_ff.tick;

    chk_tick_sec_only: assert property (@(posedge clock) disable iff (rst)
        st_ff.tick |-> st_ff.sec == 6'h0)
        else $error("tick with nonzero second count");
endmodule : iwd_tick
`default_nettype wire

// ---- logic/iwd_watchdog.sv ----
// Watchdog unit behind an index/data I/O port pair, with system reset out.
// Assumes one-cycle io_wr/io_rd strobes synchronous to clock.
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// - Count down from loaded value; assert system reset on reaching zero.
// - Index port write selects register; data port moves its contents.
// - Unlock code on index port required; accesses ignored while locked.
// - Logical device select picks the watchdog for later indices.
// - Writing one to enable index lets the watchdog count run; register decode does not depend on it.
// - Writing activate value to activate index turns the watchdog on.
// - Eight-bit timeout count held at timer value index, port reachable.
// - Count zero disables timeout; n gives n time-base units.
// - Seconds code at time-base index makes each unit one second.
// - Minutes code at time-base index makes each unit one minute.
module iwd_watchdog #(
    parameter int unsigned SEC_CYCLES = iwd_pkg::SEC_CYCLES
) (
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic [15:0] io_addr,
    input  wire logic        io_wr,
    input  wire logic        io_rd,
    input  wire logic [7:0]  io_wdata,
    output logic      [7:0]  io_rdata,
    output logic             io_rvalid,
    output logic             sys_reset
);
    import iwd_pkg::*;

    typedef struct packed {
        logic       unlocked;
        logic [7:0] index;
        logic [7:0] ldn;
        logic [7:0] enable;
        logic [7:0] activate;
        logic [7:0] tbase;
        logic [7:0] tvalue;
        logic [7:0] count;
        logic       counting;
        logic [4:0] rst_cnt;
        logic       sys_reset;
        logic [7:0] rdata;
        logic       rvalid;
    } iwd_st_t;

    iwd_st_t    st_ff;
    iwd_st_t    nxt_st;
    logic       tick;
    logic       run;
    logic       reload;
    logic       sel;
    logic       wr_idx;
    logic       wr_dat;
    logic       rd_dat;
    logic [7:0] rd_mux;

    assign wr_idx = io_wr && io_addr == IDX_PORT;
    assign wr_dat = io_wr && io_addr == DATA_PORT && st_ff.unlocked;
    assign rd_dat = io_rd && io_addr == DATA_PORT && st_ff.unlocked;
    assign sel = st_ff.ldn == WATCHDOG_LDN;
    assign reload = wr_dat && sel && st_ff.index == REG_TVALUE;
    assign run = st_ff.counting && st_ff.enable == ENABLE_VAL &&
                 st_ff.activate == ACTIVATE_VAL;

    iwd_tick #(
        .SEC_CYCLES (SEC_CYCLES)
    ) u_tick (
        .clock   (clock),
        .rst     (rst),
        .run     (run),
        .restart (reload),
        .minutes (st_ff.tbase == TB_MINUTES),
        .tick    (tick)
    );

    always_comb begin
        rd_mux = RST_ZERO;
        if (st_ff.index == REG_LDN) begin
            rd_mux = st_ff.ldn;
        end else if (sel) begin
            case (st_ff.index)
                REG_ENABLE:   rd_mux = st_ff.enable;
                REG_ACTIVATE: rd_mux = st_ff.activate;
                REG_TBASE:    rd_mux = st_ff.tbase;
                REG_TVALUE:   rd_mux = st_ff.count;
                default:      rd_mux = RST_ZERO;
            endcase
        end
    end

    always_comb begin
        nxt_st = st_ff;
        nxt_st.rvalid = 1'b0;
        if (wr_idx) begin
            if (!st_ff.unlocked) begin
                nxt_st.unlocked = io_wdata == UNLOCK_CODE;
            end else if (io_wdata == LOCK_CODE) begin
                nxt_st.unlocked = 1'b0;
            end else begin
                nxt_st.index = io_wdata;
            end
        end
        if (wr_dat) begin
            if (st_ff.index == REG_LDN) begin
                nxt_st.ldn = io_wdata;
            end else if (sel) begin
                case (st_ff.index)
                    REG_ENABLE:   nxt_st.enable = io_wdata;
                    REG_ACTIVATE: nxt_st.activate = io_wdata;
                    REG_TBASE:    nxt_st.tbase = io_wdata;
                    REG_TVALUE: begin
                        nxt_st.tvalue = io_wdata;
                        nxt_st.count = io_wdata;
                        nxt_st.counting = io_wdata != RST_ZERO;
                    end
                    default: ;
                endcase
            end
        end
        if (rd_dat) begin
            nxt_st.rdata = rd_mux;
            nxt_st.rvalid = 1'b1;
        end
        if (st_ff.rst_cnt != 5'h0) begin
            nxt_st.rst_cnt = st_ff.rst_cnt - 5'h01;
        end
        // A fresh expiry outranks a running pulse and restarts it.
        if (!reload && run && tick) begin
            nxt_st.count = st_ff.count - 8'h01;
            if (st_ff.count == 8'h01) begin
                nxt_st.counting = 1'b0;
                nxt_st.rst_cnt = 5'(RESET_PULSE);
            end
        end
        nxt_st.sys_reset = nxt_st.rst_cnt != 5'h0;
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            st_ff <= '0;
            st_ff.tbase <= TB_SECONDS;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign io_rdata = st_ff.rdata;
    assign io_rvalid = st_ff.rvalid;
    assign sys_reset = st_ff.sys_reset;

    // Last tick of a running count: the step that fires the reset request.
    sequence s_expire;
        run && tick && !reload && st_ff.count == 8'h01;
    endsequence

    // Any earlier tick of a running count only steps it down by one.
    sequence s_count_step;
        run && tick && !reload && st_ff.count > 8'h01;
    endsequence

    // The reset request stands for sixteen cycles and then drops.
    sequence s_reset_pulse;
        sys_reset [*8] ##1 sys_reset [*8] ##1 !sys_reset;
    endsequence

    sequence s_data_read;
        rd_dat;
    endsequence

    sequence s_relock;
        st_ff.unlocked && wr_idx && io_wdata == LOCK_CODE;
    endsequence

    chk_expire_reset: assert property (@(posedge clock) disable iff (rst)
        s_expire |=> s_reset_pulse)
        else $error("no system reset after count expiry");
    chk_count_step: assert property (@(posedge clock) disable iff (rst)
        s_count_step |=> st_ff.count == $past(st_ff.count) - 8'h01)
        else $error("count did not step down on tick");
    chk_reset_source: assert property (@(posedge clock) disable iff (rst)
        $rose(sys_reset) |-> $past(run) && $past(tick))
        else $error("system reset without an expiring count");
    chk_read_answer: assert property (@(posedge clock) disable iff (rst)
        s_data_read |=> io_rvalid)
        else $error("data port read not answered");
    chk_no_stray_answer: assert property (@(posedge clock) disable iff (rst)
        !rd_dat |=> !io_rvalid)
        else $error("read answer without a taken read");
    chk_relock_code: assert property (@(posedge clock) disable iff (rst)
        s_relock |=> !st_ff.unlocked)
        else $error("relock code not honoured");
    chk_locked_ignore: assert property (@(posedge clock) disable iff (rst)
        !st_ff.unlocked && io_wr && io_addr == DATA_PORT |=>
        $stable(st_ff.ldn) && $stable(st_ff.tvalue))
        else $error("data write took effect while locked");
    chk_unlock_code: assert property (@(posedge clock) disable iff (rst)
        !st_ff.unlocked && wr_idx && io_wdata == UNLOCK_CODE |=>
        st_ff.unlocked)
        else $error("unlock code not accepted");
    chk_reload_count: assert property (@(posedge clock) disable iff (rst)
        reload |=> st_ff.count == $past(io_wdata))
        else $error("timer value write did not reload count");
    chk_zero_disable: assert property (@(posedge clock) disable iff (rst)
        reload && io_wdata == RST_ZERO |=> !st_ff.counting)
        else $error("zero count did not disable timeout");
    chk_inactive_hold: assert property (@(posedge clock) disable iff (rst)
        !run && !reload |=> $stable(st_ff.count))
        else $error("count moved while inactive");
    chk_read_path: assert property (@(posedge clock) disable iff (rst)
        rd_dat && sel && st_ff.index == REG_TVALUE |=>
        io_rvalid && io_rdata == $past(st_ff.count))
        else $error("timer value read mismatch");
    chk_ldn_select: assert property (@(posedge clock) disable iff (rst)
        wr_dat && st_ff.index == REG_LDN |=> st_ff.ldn == $past(io_wdata))
        else $error("logical device select not stored");
endmodule : iwd_watchdog
`default_nettype wire

// ---- bench/iwd_host.sv ----
// Host software model: I/O port writes and reads on the index/data pair.
// Assumes the bench calls its tasks; strobes change just after clock edges.
`timescale 1ns/100ps
`default_nettype none
module iwd_host (
    input  wire logic        clock,
    output logic      [15:0] io_addr,
    output logic             io_wr,
    output logic             io_rd,
    output logic      [7:0]  io_wdata,
    input  wire logic [7:0]  io_rdata,
    input  wire logic        io_rvalid
);
    import iwd_pkg::*;
    initial begin
        io_addr = 16'h0080;
        io_wr = 1'b0;
        io_rd = 1'b0;
        io_wdata = 8'h00;
    end
    // Released lines show the inverse so stale values cannot match.
    task automatic put(input logic [15:0] a, input logic [7:0] d);
        @(posedge clock);
        io_addr <= a;
        io_wdata <= d;
        io_wr <= 1'b1;
        @(posedge clock);
        io_wr <= 1'b0;
        io_addr <= ~a;
        io_wdata <= ~d;
    endtask : put
    task automatic setreg(input logic [7:0] idx, input logic [7:0] d);
        put(IDX_PORT, idx);
        put(DATA_PORT, d);
    endtask : setreg
    task automatic get(output logic [7:0] d, output logic ok);
        @(posedge clock);
        io_addr <= DATA_PORT;
        io_rd <= 1'b1;
        @(posedge clock);
        io_rd <= 1'b0;
        io_addr <= 16'h0080;
        @(negedge clock);
        ok = io_rvalid;
        d = io_rdata;
    endtask : get
    task automatic arm(input logic [7:0] tb, input logic [7:0] n);
        put(IDX_PORT, UNLOCK_CODE);
        setreg(REG_LDN, WATCHDOG_LDN);
        setreg(REG_ENABLE, ENABLE_VAL);
        setreg(REG_ACTIVATE, ACTIVATE_VAL);
        setreg(REG_TBASE, tb);
        setreg(REG_TVALUE, n);
    endtask : arm
endmodule : iwd_host
`default_nettype wire

// ---- bench/testbench.sv ----
// Self-checking bench for the watchdog unit behind the I/O port pair.
// Assumes a shortened second of S cycles; the host model drives the ports.
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import iwd_pkg::*;
    localparam int S = 20;
    logic clock, rst, io_wr, io_rd, io_rvalid, sys_reset, ok;
    logic [15:0] io_addr;
    logic [7:0] io_wdata, io_rdata, d, n;
    logic [31:0] seed = 32'h0000002F;
    logic [7:0] exp_q[$];
    int n_fail = 0, total_checks = 0, c;
    iwd_host host_u (.clock(clock), .io_addr(io_addr), .io_wr(io_wr),
        .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata),
        .io_rvalid(io_rvalid));
    iwd_watchdog #(.SEC_CYCLES(S)) dut_u (.clock(clock), .rst(rst),
        .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata),
        .io_rdata(io_rdata), .io_rvalid(io_rvalid), .sys_reset(sys_reset));
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // Counts cycles until the reset request shows, up to lim.
    task automatic wait_rst(input int lim, output int k);
        k = 0;
        while (sys_reset !== 1'b1 && k < lim) begin
            @(negedge clock);
            k++;
        end
    endtask : wait_rst
    task automatic finish_test;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : finish_test
    initial begin
        #100000;
        n_fail++;
        finish_test();
    end
    initial begin
        rst = 1'b1;
        repeat (20) @(posedge clock);
        rst <= 1'b0;
        host_u.get(d, ok);
        check({7'h00, ok}, 8'h00);
        host_u.setreg(REG_LDN, WATCHDOG_LDN);
        host_u.put(IDX_PORT, UNLOCK_CODE);
        host_u.put(IDX_PORT, REG_LDN);
        host_u.get(d, ok);
        check(d, 8'h00);
        check({7'h00, ok}, 8'h01);
        host_u.put(DATA_PORT, WATCHDOG_LDN);
        host_u.setreg(REG_TVALUE, 8'h01);
        wait_rst(100, c);
        check({7'h00, c == 100}, 8'h01);
        $display("test locked and idle done");
        host_u.arm(TB_SECONDS, 8'h03);
        wait_rst(4000, c);
        check({7'h00, c >= 3 * S - 2 && c <= 3 * S + 3}, 8'h01);
        for (int i = 1; i <= 16; i++) begin
            @(negedge clock);
            check({7'h00, sys_reset}, {7'h00, i < 16});
        end
        host_u.get(d, ok);
        check(d, 8'h00);
        $display("test seconds expiry done");
        host_u.setreg(REG_TVALUE, 8'h02);
        repeat (S * 3 / 2) @(negedge clock);
        host_u.get(d, ok);
        check(d, 8'h01);
        host_u.setreg(REG_TVALUE, 8'h02);
        repeat (30) @(negedge clock);
        check({7'h00, sys_reset}, 8'h00);
        wait_rst(4000, c);
        repeat (20) @(negedge clock);
        host_u.setreg(REG_TVALUE, 8'h00);
        wait_rst(300, c);
        check({7'h00, c == 300}, 8'h01);
        $display("test reload and disable done");
        for (int i = 0; i < 4; i++) begin
            seed = xs(seed);
            n = seed[7:0];
            exp_q.push_back(n);
            host_u.setreg(REG_TVALUE, n);
            host_u.get(d, ok);
            check(d, exp_q.pop_front());
            check({7'h00, ok}, 8'h01);
        end
        $display("test random readback done");
        host_u.setreg(REG_TBASE, TB_MINUTES);
        host_u.setreg(REG_TVALUE, 8'h01);
        wait_rst(4000, c);
        check({7'h00, c >= 60 * S - 2 && c <= 60 * S + 3}, 8'h01);
        host_u.put(IDX_PORT, LOCK_CODE);
        host_u.get(d, ok);
        check({7'h00, ok}, 8'h00);
        $display("test minutes and relock done");
        @(posedge clock);
        rst <= 1'b1;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        host_u.put(IDX_PORT, UNLOCK_CODE);
        host_u.setreg(REG_LDN, WATCHDOG_LDN);
        host_u.put(IDX_PORT, REG_TBASE);
        host_u.get(d, ok);
        check(d, TB_SECONDS);
        check({7'h00, ok}, 8'h01);
        $display("test mid-run reset done");
        finish_test();
    end
endmodule : testbench
`default_nettype wire
